//--- rtl/adc_control_interface.sv
`timescale 1ns/100ps
// Operation
// - pin enable bit makes port6 pin analog
// - pin0: ext interrupt over analog over gpio
// - reference select: supply at 0, pin at 1
// - divider codes give 4, 16, 1, 2
// - power bit zero gates off the conversion clock tick
// - channel codes 0-5 valid, 6-7 none
// - reference pin function beats digital io
// - completion loads result, clears run, flags
// - high result buffer ignores writes
// - low buffer holds two bits, rest zero
// - done flag hardware set, software cleared, masked
module adc_control_interface (
    input  wire logic                            clock_i,
    input  wire logic                            resetn_i,
    input  wire logic [adc_ctrl_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [adc_ctrl_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                            wr_i,
    input  wire logic                            rd_i,
    output logic      [adc_ctrl_pkg::DATA_W-1:0] rdata_o,
    input  wire logic                            ext_int_en_i,
    input  wire logic                            conv_done_i,
    input  wire logic [adc_ctrl_pkg::RES_W-1:0]  conv_result_i,
    output adc_ctrl_pkg::core_req_t              core_req_o,
    output adc_ctrl_pkg::pin_mux_t               pin_mux_o,
    output logic                                 wake_o,
    output logic                                 irq_o
);
    import adc_ctrl_pkg::*;

    logic [PIN_N-1:0]  pin_en_q;
    logic [DATA_W-1:0] ctl_q;
    logic [DATA_W-1:0] res_hi_q;
    logic [1:0]        res_lo_q;
    logic              done_q;
    logic              mask_q;
    logic              wake_en_q;
    logic              start_q;
    logic [3:0]        div_cnt_q;
    logic [DATA_W-1:0] rdata_q;
    logic              tick_q;
    logic              wr_pin;
    logic              wr_ctl;
    logic              run_set;
    logic [3:0]        div_top;

    // conversion clock ratio minus one for a divider code
    function automatic logic [3:0] div_last(input logic [1:0] code);
        case (code)
            DIV_CODE_4:  div_last = DIV_RATIO_4;
            DIV_CODE_16: div_last = DIV_RATIO_16;
            DIV_CODE_1:  div_last = DIV_RATIO_1;
            DIV_CODE_2:  div_last = DIV_RATIO_2;
            default:     div_last = DIV_RATIO_4;
        endcase
    endfunction

    // write decode
    assign wr_pin  = wr_i && (addr_i == OFS_PIN_EN);
    assign wr_ctl  = wr_i && (addr_i == OFS_CONTROL);
    assign run_set = wr_ctl && wdata_i[CTL_RUN];
    assign div_top = div_last(ctl_q[CTL_DIV_HI:CTL_DIV_LO]);

    // pin enables, upper bits not stored
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_en_q <= RESET_BYTE[PIN_N-1:0];
        end else if (wr_pin) begin
            pin_en_q <= wdata_i[PIN_N-1:0];
        end
    end

    // control fields other than run; software cannot clear run
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctl_q <= RESET_BYTE;
        end else begin
            if (wr_ctl) begin
                ctl_q[CTL_REF:CTL_DIV_LO] <= wdata_i[CTL_REF:CTL_DIV_LO];
                ctl_q[CTL_PWR:0]          <= wdata_i[CTL_PWR:0];
            end
            if (run_set) begin
                ctl_q[CTL_RUN] <= 1'b1;
            end else if (conv_done_i && ctl_q[CTL_RUN]) begin
                ctl_q[CTL_RUN] <= 1'b0;
            end
        end
    end

    // one-cycle start toward the core on each write of one
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            start_q <= 1'b0;
        end else begin
            start_q <= run_set;
        end
    end

    // result buffers load only from the core, never from writes
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            res_hi_q <= RESET_BYTE;
            res_lo_q <= RESET_BYTE[1:0];
        end else if (conv_done_i && ctl_q[CTL_RUN]) begin
            res_hi_q <= conv_result_i[RES_W-1:2];
            res_lo_q <= conv_result_i[1:0];
        end
    end

    // done flag: completion beats a same-cycle write-one clear
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            done_q <= 1'b0;
        end else if (conv_done_i && ctl_q[CTL_RUN]) begin
            done_q <= 1'b1;
        end else if (wr_i && (addr_i == OFS_STATUS) && wdata_i[DONE_BIT]) begin
            done_q <= 1'b0;
        end
    end

    // mask and wake enable
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mask_q    <= 1'b0;
            wake_en_q <= 1'b0;
        end else begin
            if (wr_i && (addr_i == OFS_MASK)) begin
                mask_q <= wdata_i[DONE_BIT];
            end
            if (wr_i && (addr_i == OFS_WAKE)) begin
                wake_en_q <= wdata_i[WAKE_BIT];
            end
        end
    end

    // conversion clock divider; restarts when a conversion starts
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_cnt_q <= 4'h0;
            tick_q    <= 1'b0;
        end else if (run_set) begin
            div_cnt_q <= 4'h0;
            tick_q    <= 1'b0;
        end else if (div_cnt_q >= div_top) begin
            div_cnt_q <= 4'h0;
            tick_q    <= 1'b1;
        end else begin
            div_cnt_q <= div_cnt_q + 4'h1;
            tick_q    <= 1'b0;
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_q <= RESET_BYTE;
        end else if (rd_i) begin
            case (addr_i)
                OFS_PIN_EN:  rdata_q <= {2'h0, pin_en_q} & PIN_EN_MASK;
                OFS_CONTROL: rdata_q <= ctl_q;
                OFS_RES_HI:  rdata_q <= res_hi_q;
                OFS_RES_LO:  rdata_q <= {6'h00, res_lo_q};
                OFS_STATUS:  rdata_q <= {1'b0, done_q & mask_q, 6'h00};
                OFS_MASK:    rdata_q <= {1'b0, mask_q, 6'h00};
                OFS_WAKE:    rdata_q <= {1'b0, wake_en_q, 6'h00};
                default:     rdata_q <= RESET_BYTE;
            endcase
        end else begin
            rdata_q <= RESET_BYTE;
        end
    end
    assign rdata_o = rdata_q;

    // core request; the divider tick only matters while powered
    always_comb begin
        core_req_o.power_on      = ctl_q[CTL_PWR];
        core_req_o.ref_external  = ctl_q[CTL_REF];
        core_req_o.channel       = ctl_q[CTL_CH_HI:0];
        core_req_o.channel_valid = (ctl_q[CTL_CH_HI:0] <= CH_LAST);
        core_req_o.start         = start_q;
        core_req_o.clk_tick      = tick_q & ctl_q[CTL_PWR];
    end

    // pin steering; software is expected to change it only while idle,
    // so no interlock is built here
    always_comb begin
        pin_mux_o.analog_en       = pin_en_q;
        pin_mux_o.analog_en[0]    = pin_en_q[0] & ~ext_int_en_i;
        pin_mux_o.digital_en      = ~pin_en_q;
        pin_mux_o.digital_en[0]   = ~pin_en_q[0] & ~ext_int_en_i;
        pin_mux_o.pin0_ext_int    = ext_int_en_i;
        pin_mux_o.ref_pin_analog  = ctl_q[CTL_REF];
        pin_mux_o.ref_pin_digital = ~ctl_q[CTL_REF];
    end

    // interrupt level and wake request
    assign irq_o  = done_q & mask_q;
    assign wake_o = done_q & wake_en_q;

endmodule // adc_control_interface

//--- rtl/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
    // register port geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int RES_W  = 10;
    localparam int CH_W   = 3;
    localparam int PIN_N  = 6;
    // register offsets
    localparam logic [4:0] OFS_PIN_EN  = 5'h05;
    localparam logic [4:0] OFS_CONTROL = 5'h06;
    localparam logic [4:0] OFS_RES_HI  = 5'h08;
    localparam logic [4:0] OFS_RES_LO  = 5'h09;
    localparam logic [4:0] OFS_STATUS  = 5'h10;
    localparam logic [4:0] OFS_MASK    = 5'h11;
    localparam logic [4:0] OFS_WAKE    = 5'h12;
    // control register fields
    localparam int CTL_REF    = 7;
    localparam int CTL_DIV_HI = 6;
    localparam int CTL_DIV_LO = 5;
    localparam int CTL_RUN    = 4;
    localparam int CTL_PWR    = 3;
    localparam int CTL_CH_HI  = 2;
    // status, mask and wake layout
    localparam int DONE_BIT   = 6;
    localparam int WAKE_BIT   = 6;
    localparam logic [7:0] PIN_EN_MASK = 8'h3F;
    localparam logic [7:0] RESET_BYTE  = 8'h00;
    localparam logic [2:0] CH_LAST     = 3'h5;
    // divider codes and ratios
    localparam logic [1:0] DIV_CODE_4  = 2'h0;
    localparam logic [1:0] DIV_CODE_16 = 2'h1;
    localparam logic [1:0] DIV_CODE_1  = 2'h2;
    localparam logic [1:0] DIV_CODE_2  = 2'h3;
    localparam logic [3:0] DIV_RATIO_4  = 4'h3;
    localparam logic [3:0] DIV_RATIO_16 = 4'hF;
    localparam logic [3:0] DIV_RATIO_1  = 4'h0;
    localparam logic [3:0] DIV_RATIO_2  = 4'h1;

    // request toward the analog converter core
    typedef struct packed {
        logic            power_on;
        logic            ref_external;
        logic            channel_valid;
        logic [CH_W-1:0] channel;
        logic            start;
        logic            clk_tick;
    } core_req_t;

    // pin function steering for port 6 and the reference pin
    typedef struct packed {
        logic [PIN_N-1:0] analog_en;
        logic [PIN_N-1:0] digital_en;
        logic             pin0_ext_int;
        logic             ref_pin_analog;
        logic             ref_pin_digital;
    } pin_mux_t;
endpackage

//--- verif/adc_core_model.sv
`timescale 1ns/100ps
module adc_core_model (
    input  wire logic                    clock_i,
    input  wire logic                    resetn_i,
    input  wire adc_ctrl_pkg::core_req_t req_i,
    input  wire logic [9:0]              value_i,
    output logic                         done_o,
    output logic [9:0]                   result_o
);
    logic [3:0] left_q;
    // eight divided ticks per conversion; result toggles while not valid
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            left_q   <= 4'h0;
            done_o   <= 1'b0;
            result_o <= 10'h000;
        end else begin
            done_o   <= 1'b0;
            result_o <= ~result_o;
            if (req_i.start) begin
                left_q <= 4'h8;
            end else if (left_q != 4'h0 && req_i.clk_tick) begin
                left_q <= left_q - 4'h1;
                if (left_q == 4'h1) begin
                    done_o   <= 1'b1;
                    result_o <= value_i;
                end
            end
        end
    end
endmodule // adc_core_model

//--- verif/adc_control_interface_chk.sv
`timescale 1ns/100ps
module adc_control_interface_chk (
    input wire logic                    clock_i,
    input wire logic                    resetn_i,
    input wire logic [4:0]              addr_i,
    input wire logic [7:0]              wdata_i,
    input wire logic                    wr_i,
    input wire logic                    rd_i,
    input wire logic [7:0]              rdata_o,
    input wire logic                    ext_int_en_i,
    input wire adc_ctrl_pkg::core_req_t core_req_o,
    input wire adc_ctrl_pkg::pin_mux_t  pin_mux_o,
    input wire logic                    irq_o
);
    import adc_ctrl_pkg::*;
    default clocking dc @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);
    a_pin0_int: assert property (ext_int_en_i |-> !pin_mux_o.analog_en[0]
        && !pin_mux_o.digital_en[0]) else $error("pin0 not yielded");
    a_pin_split: assert property (!ext_int_en_i |->
        pin_mux_o.digital_en == ~pin_mux_o.analog_en) else $error("pin split");
    a_ref_pin: assert property (pin_mux_o.ref_pin_analog == core_req_o.ref_external
        && pin_mux_o.ref_pin_digital != pin_mux_o.ref_pin_analog) else $error("ref pin");
    a_chan: assert property (core_req_o.channel_valid ==
        (core_req_o.channel <= CH_LAST)) else $error("channel valid");
    a_start: assert property (wr_i && addr_i == OFS_CONTROL && wdata_i[CTL_RUN]
        |=> core_req_o.start) else $error("no start");
    a_pwr_off: assert property (!core_req_o.power_on |-> !core_req_o.clk_tick)
        else $error("tick while off");
    a_lo_zero: assert property (rd_i && addr_i == OFS_RES_LO |=> rdata_o[7:2] == 6'h00)
        else $error("low bits");
    a_reserved: assert property (rd_i && addr_i == 5'h07 |=> rdata_o == 8'h00)
        else $error("reserved read");
    a_irq_hold: assert property (irq_o && !wr_i |=> irq_o)
        else $error("irq dropped");
endmodule // adc_control_interface_chk
bind adc_control_interface adc_control_interface_chk chk (.clock_i, .resetn_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .ext_int_en_i, .core_req_o, .pin_mux_o, .irq_o);

//--- verif/adc_control_interface_tb.sv
`timescale 1ns/100ps
module adc_control_interface_tb;
    import adc_ctrl_pkg::*;
    logic       clock_i, resetn_i, wr_i, rd_i, ext_int_en_i, conv_done_i, wake_o, irq_o;
    logic [4:0] addr_i;
    logic [7:0] wdata_i, rdata_o;
    logic [9:0] value, conv_result_i;
    core_req_t  core_req_o;
    pin_mux_t   pin_mux_o;
    int         n_mismatch, n_checks, cycles;
    adc_control_interface DUT (.clock_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .ext_int_en_i, .conv_done_i, .conv_result_i, .core_req_o, .pin_mux_o,
        .wake_o, .irq_o);
    adc_core_model core (.clock_i, .resetn_i, .req_i(core_req_o), .value_i(value),
        .done_o(conv_done_i), .result_o(conv_result_i));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // every access starts and ends on a rising edge; the idle cycle keeps strobes single
    task wr(input logic [4:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        @(posedge clock_i);
    endtask
    // read data stand only in the cycle after the strobe: look mid-cycle
    task rd(input logic [4:0] a, input logic [7:0] e);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(negedge clock_i);
        check(rdata_o, e);
        @(posedge clock_i);
    endtask
    task results;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task t_reset;
        logic [4:0] regs [7] = '{OFS_PIN_EN, OFS_CONTROL, OFS_RES_HI, OFS_RES_LO,
                                 OFS_STATUS, OFS_MASK, OFS_WAKE};
        foreach (regs[i]) rd(regs[i], 8'h00);
        check({2'h0, pin_mux_o.digital_en}, 8'h3F);
    endtask
    task t_pins;
        wr(OFS_PIN_EN, 8'hFF);
        rd(OFS_PIN_EN, 8'h3F);
        check({2'h0, pin_mux_o.analog_en}, 8'h3F);
        ext_int_en_i <= 1'b1;
        @(posedge clock_i);
        check({2'h0, pin_mux_o.analog_en}, 8'h3E);
        ext_int_en_i <= 1'b0;
        wr(5'h07, 8'hFF);
        rd(5'h07, 8'h00);
    endtask
    task t_control;
        logic [7:0] ratio [4] = '{8'h04, 8'h10, 8'h01, 8'h02};
        int k, t0, gap;
        for (int c = 0; c < 4; c++) begin
            wr(OFS_CONTROL, {1'b0, c[1:0], 5'h08});
            t0 = -1;
            gap = 0;
            for (k = 0; k < 40; k++) begin
                if (core_req_o.clk_tick === 1'b1) begin
                    if (t0 >= 0 && gap == 0) gap = k - t0;
                    t0 = k;
                end
                @(posedge clock_i);
            end
            check(gap[7:0], ratio[c]);
        end
        wr(OFS_CONTROL, 8'h80);
        check({6'h0, pin_mux_o.ref_pin_analog, pin_mux_o.ref_pin_digital}, 8'h02);
        for (int ch = 0; ch < 8; ch++) begin
            wr(OFS_CONTROL, {5'h01, ch[2:0]});
            check({7'h0, core_req_o.channel_valid}, {7'h0, ch < 6});
        end
    endtask
    task t_convert;
        wr(OFS_MASK, 8'h40);
        // wake enable set before starting, as software must
        wr(OFS_WAKE, 8'h40);
        value = 10'h2B6;
        wr(OFS_CONTROL, 8'h5A);
        wr(OFS_CONTROL, 8'h4A);
        rd(OFS_CONTROL, 8'h5A);
        for (int i = 0; i < 30 && irq_o !== 1'b1; i++) begin
            @(posedge clock_i);
        end
        check({6'h0, irq_o, wake_o}, 8'h03);
        rd(OFS_RES_HI, 8'hAD);
        rd(OFS_RES_LO, 8'h02);
        rd(OFS_CONTROL, 8'h4A);
        wr(OFS_RES_HI, 8'h00);
        rd(OFS_RES_HI, 8'hAD);
        wr(OFS_MASK, 8'h00);
        rd(OFS_STATUS, 8'h00);
        wr(OFS_MASK, 8'h40);
        rd(OFS_STATUS, 8'h40);
        wr(OFS_STATUS, 8'h40);
        check({7'h0, irq_o}, 8'h00);
    endtask
    // cycle ceiling well above the few hundred cycles the run needs
    always @(posedge clock_i) begin
        cycles++;
        if (cycles > 2000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    initial begin
        {resetn_i, wr_i, rd_i, ext_int_en_i, addr_i, wdata_i, value} = '0;
        repeat (12) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        t_reset();
        t_pins();
        t_control();
        t_convert();
        results();
    end
endmodule // adc_control_interface_tb
